// >>> logic/ams_map.svh
// Register offsets, field positions, reset values and sizes of the analog multiplexer channel select block.
`ifndef AMS_MAP_SVH
`define AMS_MAP_SVH

// Byte offsets of the register words on the Avalon-MM slave.
`define AMS_OFF_ENABLE 4'h0
`define AMS_OFF_CHANNEL 4'h4
`define AMS_OFF_STEP 4'h8
`define AMS_OFF_STATUS 4'hC
`define AMS_ADDR_W 4

// Field positions.
`define AMS_AUTO_BIT 5
`define AMS_CODE_LSB 0
`define AMS_CODE_MSB 3
`define AMS_ST_CODE_LSB 0
`define AMS_ST_AUTO_BIT 5
`define AMS_ST_NEXT_LSB 8
`define AMS_ST_ACTIVE_LSB 12
`define AMS_ST_MISMATCH_LSB 14
`define AMS_ST_PRESENT_LSB 16
`define AMS_ST_SWITCH_LSB 16

// Sizes of the channel code and of the multiplexer modules.
`define AMS_CODE_W 4
`define AMS_LOW_W 3
`define AMS_LINES 8
`define AMS_MODULES 2
`define AMS_CHANNELS 16

// Reset values.
`define AMS_CODE_RST 4'h0
`define AMS_AUTO_RST 1'b0
`define AMS_SWITCH_RST 16'hFFFF
`define AMS_DATA_RST 32'h0000_0000
`define AMS_CODE_ONE 4'h1

`endif

// >>> logic/ams_pkg.sv
// Types shared by the analog multiplexer channel select design.
`include "ams_map.svh"

package ams_pkg;

	// Channel selection mode.
	typedef enum logic [0:0] {
		AMS_MODE_FIXED = 1'b0,
		AMS_MODE_SCAN = 1'b1
	} ams_mode_e;

	// Avalon slave handshake state.
	typedef enum logic [0:0] {
		AMS_BUS_IDLE = 1'b0,
		AMS_BUS_ACK = 1'b1
	} ams_bus_e;

	// One Avalon-MM request as seen by the slave.
	typedef struct packed {
		logic [`AMS_ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} ams_av_req_s;

	// Per-module view of the channel code.
	typedef struct packed {
		logic [`AMS_LOW_W-1:0] low_code;
		logic module_select_bit;
		logic strap_high;
		logic slot_high;
		logic present;
	} ams_mod_in_s;

endpackage : ams_pkg

// >>> logic/ams_step_counter.sv
// Mode selection and next-channel counter that produce the four channel select bits.
`timescale 1ns/1ns
`default_nettype none
`include "ams_map.svh"

module ams_step_counter
	import ams_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire ams_mode_e mode,
	input wire logic [`AMS_CODE_W-1:0] channel_number_register,
	input wire logic step,
	output logic [`AMS_CODE_W-1:0] channel_select_bits,
	output logic [`AMS_CODE_W-1:0] next_channel
);

	logic [`AMS_CODE_W-1:0] next_ff;
	logic [`AMS_CODE_W-1:0] nxt_next;
	logic [`AMS_CODE_W-1:0] code_ff;
	logic [`AMS_CODE_W-1:0] nxt_code;

	// The counter walks 0 to 15 and wraps; it only moves in scan mode so a fixed selection never disturbs it.
	assign nxt_next = (mode == AMS_MODE_SCAN && step) ? next_ff + `AMS_CODE_ONE : next_ff; // [R2]

	// Scan mode takes the counter, fixed mode the software channel register.
	assign nxt_code = (mode == AMS_MODE_SCAN) ? next_ff : channel_number_register; // [R2] [R3]

	// Both registers are plain state; the code is registered so the decoders see a clean level.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			next_ff <= `AMS_CODE_RST;
			code_ff <= `AMS_CODE_RST;
		end else begin
			next_ff <= nxt_next;
			code_ff <= nxt_code;
		end
	end

	assign channel_select_bits = code_ff;
	assign next_channel = next_ff;

endmodule : ams_step_counter
`default_nettype wire

// >>> logic/ams_decoder.sv
// One eight-channel multiplexer module: decodes the low code bits into active-low switch lines.
`timescale 1ns/1ns
`default_nettype none
`include "ams_map.svh"

module ams_decoder
	import ams_pkg::*;
(
	input wire ams_mod_in_s mod_in,
	output logic [`AMS_LINES-1:0] switch_on_n,
	output logic active,
	output logic strap_mismatch
);

	logic strap_ok;

	// A module whose strap does not match its slot stays silent, so two modules never fight the node.
	assign strap_ok = (mod_in.strap_high == mod_in.slot_high); // [R8]
	assign strap_mismatch = mod_in.present & ~strap_ok;

	// The select bit arrives already inverted for the upper module, so both answer to a low level.
	assign active = mod_in.present & strap_ok & ~mod_in.module_select_bit; // [R7]

	// Binary code maps straight to the line number; only the matching line goes low.
	genvar i;
	generate
		for (i = 0; i < `AMS_LINES; i = i + 1) begin : g_line
			assign switch_on_n[i] = ~(active && (mod_in.low_code == 3'(i))); // [R4] [R5]
		end
	endgenerate

endmodule : ams_decoder
`default_nettype wire

// >>> logic/ams_top.sv
// Channel select for a sixteen-channel analog multiplexer, with an Avalon-MM register slave.
//
// Function
// R1: Enable write bit 5 sets scan mode.
// R2: Scan mode steps channels 0 to 15.
// R3: Fixed mode uses the software channel register.
// R4: Decode code; exactly one line driven low.
// R5: Binary code selects the same line number.
// R6: All other switches stay cut off.
// R7: Top bit inverted selects the upper module.
// R8: Strap fixes each module to its half.
// R9: Two eight-channel modules give sixteen channels.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ams_map.svh"

module ams_top
	import ams_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [`AMS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic convert_done,
	input wire logic [`AMS_MODULES-1:0] strap_high,
	input wire logic [`AMS_MODULES-1:0] module_present,
	output logic [`AMS_CHANNELS-1:0] switch_on_n,
	output logic [`AMS_CODE_W-1:0] channel_code
);

	// Address match, used by both the write and the read decode.
	function automatic logic ams_hit(input logic [`AMS_ADDR_W-1:0] addr, input logic [`AMS_ADDR_W-1:0] off);
		ams_hit = (addr == off);
	endfunction : ams_hit

	ams_av_req_s req;
	ams_bus_e bus_ff;
	ams_bus_e nxt_bus;
	logic req_any;
	logic commit;
	logic wr_lane0;
	logic wr_enable;
	logic wr_channel;
	logic wr_step;
	logic rd_enable;
	logic rd_channel;
	logic rd_status;
	logic step_pulse;
	ams_mode_e mode_ff;
	ams_mode_e nxt_mode;
	logic [`AMS_CODE_W-1:0] chan_ff;
	logic [`AMS_CODE_W-1:0] nxt_chan;
	logic [`AMS_CODE_W-1:0] code;
	logic [`AMS_CODE_W-1:0] next_channel;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] enable_word;
	logic [31:0] channel_word;
	logic [31:0] status_word;
	logic [`AMS_CHANNELS-1:0] switch_ff;
	logic [`AMS_CHANNELS-1:0] nxt_switch;
	logic [`AMS_MODULES-1:0] mod_active;
	logic [`AMS_MODULES-1:0] mod_mismatch;
	ams_mod_in_s mod_in [`AMS_MODULES];

	// Bundle the bus pins so the decode below reads as one request.
	assign req.address = avs_address;
	assign req.read = avs_read;
	assign req.write = avs_write;
	assign req.writedata = avs_writedata;
	assign req.byteenable = avs_byteenable;

	// Every access takes one wait state; the trade is a fixed two-cycle access for registered read data.
	assign req_any = req.read | req.write;
	assign avs_waitrequest = req_any & (bus_ff == AMS_BUS_IDLE);
	assign commit = req_any & (bus_ff == AMS_BUS_ACK);
	assign nxt_bus = (req_any && bus_ff == AMS_BUS_IDLE) ? AMS_BUS_ACK : AMS_BUS_IDLE;

	// Write decode; the writable fields all sit in byte lane 0, so other lanes alone change nothing.
	assign wr_lane0 = commit & req.write & req.byteenable[0];
	assign wr_enable = wr_lane0 & ams_hit(req.address, `AMS_OFF_ENABLE);
	assign wr_channel = wr_lane0 & ams_hit(req.address, `AMS_OFF_CHANNEL);
	assign wr_step = wr_lane0 & ams_hit(req.address, `AMS_OFF_STEP);

	// Read decode; unmapped offsets read as zero and writes to them are dropped.
	assign rd_enable = ams_hit(req.address, `AMS_OFF_ENABLE);
	assign rd_channel = ams_hit(req.address, `AMS_OFF_CHANNEL);
	assign rd_status = ams_hit(req.address, `AMS_OFF_STATUS);

	// Bit 5 of the enable write picks the mode; clear bit 5 leaves fixed mode.
	assign nxt_mode = wr_enable ? ams_mode_e'(req.writedata[`AMS_AUTO_BIT]) : mode_ff; // [R1]

	// The channel register takes the low four bits of the write data word.
	assign nxt_chan = wr_channel ? req.writedata[`AMS_CODE_MSB:`AMS_CODE_LSB] : chan_ff; // [R3]

	// Either the converter's done strobe or a software step advances the scan.
	assign step_pulse = convert_done | wr_step; // [R2]

	// Control state of the register file.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bus_ff <= AMS_BUS_IDLE;
			mode_ff <= AMS_MODE_FIXED;
			chan_ff <= `AMS_CODE_RST;
		end else begin
			bus_ff <= nxt_bus;
			mode_ff <= nxt_mode;
			chan_ff <= nxt_chan;
		end
	end

	// Mode selection and sequencing of the channel code.
	ams_step_counter u_step (
		.clock(clock),
		.rst_n(rst_n),
		.mode(mode_ff),
		.channel_number_register(chan_ff),
		.step(step_pulse),
		.channel_select_bits(code),
		.next_channel(next_channel)
	);

	// Two module slots; the upper slot gets the top code bit inverted.
	genvar g;
	generate
		for (g = 0; g < `AMS_MODULES; g = g + 1) begin : g_mod
			assign mod_in[g].low_code = code[`AMS_LOW_W-1:0];
			assign mod_in[g].module_select_bit = (g == 0) ? code[`AMS_CODE_MSB] : ~code[`AMS_CODE_MSB]; // [R7]
			assign mod_in[g].strap_high = strap_high[g]; // [R8]
			assign mod_in[g].slot_high = (g != 0);
			assign mod_in[g].present = module_present[g];

			ams_decoder u_dec (
				.mod_in(mod_in[g]),
				.switch_on_n(nxt_switch[g*`AMS_LINES +: `AMS_LINES]), // [R9]
				.active(mod_active[g]),
				.strap_mismatch(mod_mismatch[g])
			);
		end
	endgenerate

	// Register the switch lines; reset holds every switch cut off until a code is decoded.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			switch_ff <= `AMS_SWITCH_RST; // [R6]
		end else begin
			switch_ff <= nxt_switch; // [R4] [R6]
		end
	end

	assign switch_on_n = switch_ff;
	assign channel_code = code;

	// Readable words; bits not listed read as zero.
	assign enable_word = {26'h0000000, mode_ff, 5'h00};
	assign channel_word = {28'h0000000, chan_ff};
	// Exactly 32 bits: switches at the top, then mismatch, active, counter, mode and code in the low half.
	assign status_word = {switch_ff, mod_mismatch, mod_active, next_channel, 2'h0, mode_ff, 1'b0, code};

	// Read data is captured in the wait cycle, so it stands at the edge where waitrequest is low.
	assign nxt_rdata = !(req.read && bus_ff == AMS_BUS_IDLE) ? rdata_ff :
		rd_enable ? enable_word :
		rd_channel ? channel_word :
		rd_status ? status_word :
		`AMS_DATA_RST;

	// Read data register.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_ff <= `AMS_DATA_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_readdata = rdata_ff;

endmodule : ams_top
`default_nettype wire

// >>> tb/ams_assertions.sv
// Concurrent checks on the ports of the channel select block.
`timescale 1ns/1ns
`default_nettype none
`include "ams_map.svh"
module ams_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic convert_done,
	input wire logic [1:0] strap_high,
	input wire logic [1:0] module_present,
	input wire logic [15:0] switch_on_n,
	input wire logic [3:0] channel_code
);
	logic scan_ff;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// Mirror of the mode bit, since the code alone cannot tell which mode is active.
	always_ff @(posedge clock) begin
		if (!rst_n)
			scan_ff <= 1'b0;
		else if (avs_write && !avs_waitrequest && avs_address == `AMS_OFF_ENABLE && avs_byteenable[0])
			scan_ff <= avs_writedata[`AMS_AUTO_BIT];
	end
	// Switch lines: at most one low, and each lit line against the code and slot configuration one edge earlier.
	a_one_low: assert property ($countones(~switch_on_n) <= 1)
		else $error("two switches on");
	a_line_code: assert property ($past(rst_n) && $past(module_present) == 2'b11 && $past(strap_high) == 2'b10
		|-> switch_on_n == ~(16'h1 << $past(channel_code))) else $error("wrong line for code");
	a_lower_half: assert property (switch_on_n[7:0] != 8'hFF
		|-> !$past(channel_code[3]) && $past(module_present[0]) && !$past(strap_high[0])) else $error("lower bad");
	a_upper_half: assert property (switch_on_n[15:8] != 8'hFF
		|-> $past(channel_code[3]) && $past(module_present[1]) && $past(strap_high[1])) else $error("upper bad");
	// Bus handshake and the two channel code sources.
	a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state count");
	a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait while idle");
	a_scan_step: assert property (scan_ff && $past(scan_ff, 2) && convert_done && !$past(convert_done)
		|-> ##2 channel_code == $past(channel_code, 2) + 4'h1) else $error("scan step");
	a_fixed_hold: assert property (!scan_ff && !$past(scan_ff) && !avs_write && !$past(avs_write) && convert_done
		|=> $stable(channel_code)) else $error("fixed code moved");
endmodule : ams_chk
bind ams_top ams_chk ams_chk_i (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .convert_done(convert_done), .strap_high(strap_high),
	.module_present(module_present), .switch_on_n(switch_on_n), .channel_code(channel_code));
`default_nettype wire

// >>> tb/ams_conv_model.sv
// Converter side model that ends a conversion with one done pulse.
`timescale 1ns/1ns
`default_nettype none
module ams_conv_model (
	input wire logic clock,
	input wire logic start,
	input wire logic [7:0] gap,
	output var logic convert_done = 1'b0
);
	logic busy_ff = 1'b0;
	logic [7:0] wait_ff = 8'h00;
	// A long gap stands for a slow conversion; the pulse lasts one cycle only.
	always_ff @(posedge clock) begin
		convert_done <= 1'b0;
		if (start) begin
			busy_ff <= 1'b1;
			wait_ff <= gap;
		end else if (busy_ff && wait_ff == 8'h00) begin
			busy_ff <= 1'b0;
			convert_done <= 1'b1;
		end else
			wait_ff <= wait_ff - 8'h01;
	end
endmodule : ams_conv_model
`default_nettype wire

// >>> tb/ams_top_tb.sv
// Self-checking bench for the channel select block.
`timescale 1ns/1ns
`default_nettype none
`include "ams_map.svh"
module ams_top_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic convert_done;
	logic [1:0] strap_high = 2'b10;
	logic [1:0] module_present = 2'b11;
	logic [15:0] switch_on_n;
	logic [3:0] channel_code;
	logic start = 1'b0;
	logic [7:0] gap = 8'h00;
	logic [31:0] q;
	logic [7:0] cfg [3] = '{8'hC9, 8'hF1, 8'h6C};
	int failures = 0;
	int tests_run = 0;
	always #4 clock = ~clock;
	ams_top ams_top_i (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .convert_done(convert_done),
		.strap_high(strap_high), .module_present(module_present), .switch_on_n(switch_on_n),
		.channel_code(channel_code));
	ams_conv_model ams_conv_model_i (.clock(clock), .start(start), .gap(gap), .convert_done(convert_done));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// One bus access; the request is held until a rising edge samples waitrequest low, and read data is taken there.
	// Sampling right after the edge sees the values that stood at it, since the flops update later in the step.
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] rd);
		logic w;
		@(posedge clock);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge clock);
			w = avs_waitrequest;
			rd = avs_readdata;
		end while (w !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : av
	// Asks the converter model for one done pulse, then lets code and switches settle.
	task automatic pulse(input logic [7:0] g);
		int n;
		n = 0;
		@(posedge clock);
		gap <= g;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (convert_done !== 1'b1 && n < 300);
		if (convert_done !== 1'b1) begin
			failures++;
			$display("MISMATCH t=%0t no done pulse from converter", $time);
		end
		repeat (3) @(negedge clock);
	endtask : pulse
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	// Main sequence: reset, fixed mode sweep, dark slots, then scan mode.
	initial begin
		int c;
		repeat (9) @(posedge clock);
		@(negedge clock);
		chk(switch_on_n, 32'hFFFF, "reset lines");
		@(posedge clock);
		rst_n <= 1'b1;
		av(1'b0, `AMS_OFF_ENABLE, 32'h0, 4'hF, q);
		chk(q, 32'h0, "enable reset");
		av(1'b0, 4'h2, 32'h0, 4'hF, q);
		chk(q, 32'h0, "unmapped read");
		for (c = 0; c < 16; c++) begin
			av(1'b1, `AMS_OFF_CHANNEL, c, 4'hF, q);
			pulse(8'h00);
			chk(switch_on_n, 16'hFFFF ^ (16'h1 << c), "fixed line");
			chk(channel_code, c, "fixed code");
		end
		av(1'b1, `AMS_OFF_CHANNEL, 32'h3, 4'hE, q);
		av(1'b0, `AMS_OFF_CHANNEL, 32'h0, 4'hF, q);
		chk(q, 32'hF, "lane off write");
		$display("test fixed done");
		for (c = 0; c < 3; c++) begin
			@(posedge clock);
			{module_present, strap_high} <= cfg[c][7:4];
			av(1'b1, `AMS_OFF_CHANNEL, cfg[c][3:0], 4'hF, q);
			repeat (3) @(negedge clock);
			chk(switch_on_n, 32'hFFFF, "dark slot");
		end
		@(posedge clock);
		{module_present, strap_high} <= 4'hE;
		$display("test slots done");
		av(1'b1, `AMS_OFF_ENABLE, 32'hFF, 4'hF, q);
		av(1'b0, `AMS_OFF_ENABLE, 32'h0, 4'hF, q);
		chk(q, 32'h20, "enable readback");
		repeat (3) @(negedge clock);
		chk(channel_code, 32'h0, "scan start");
		for (c = 1; c < 18; c++) begin
			pulse(c[0] ? 8'h14 : 8'h00);
			chk(channel_code, c % 16, "scan code");
			chk(switch_on_n, 16'hFFFF ^ (16'h1 << (c % 16)), "scan line");
		end
		av(1'b1, `AMS_OFF_STEP, 32'h0, 4'hF, q);
		repeat (3) @(negedge clock);
		av(1'b0, `AMS_OFF_STATUS, 32'h0, 4'hF, q);
		chk(q, 32'hFFFB_1222, "status");
		av(1'b1, `AMS_OFF_ENABLE, 32'h1F, 4'hF, q);
		repeat (3) @(negedge clock);
		chk(channel_code, 32'hC, "back to fixed");
		$display("test scan done");
		complete_run();
	end
	// The tests need a few hundred cycles; this limit is far beyond that.
	initial begin
		#400000;
		failures++;
		complete_run();
	end
endmodule : ams_top_tb
`default_nettype wire
